// file: rtl/dbt_pkg.sv
// package for the dram bus training block: constants and carrier types
package dbt_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS     = 25000;
	localparam int VREF_LONG_NS      = 250;
	localparam int VREF_SHORT_NS     = 80;
	localparam int WLO_MAX_NS        = 20;
	localparam int VREF_LONG_CYC     = (VREF_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int VREF_SHORT_CYC    = (VREF_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WLO_CYC_RAW       = (WLO_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int WLO_CYC           = (WLO_CYC_RAW < 1) ? 1 : WLO_CYC_RAW;
	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int VREF_W            = 7;
	localparam int CA_W              = 6;
	localparam int DQ_W              = 16;
	localparam int LANE_W            = 8;
	localparam int CBT_FB_LSB        = 8;
	localparam logic [6:0] VREF_RESET = 7'h4d;
	localparam logic [7:0] CNT_ZERO   = 8'h00;
	localparam logic [7:0] CNT_ONE    = 8'h01;

	typedef enum logic [1:0] {
		DBT_IDLE,
		DBT_CBT_ARMED,
		DBT_CBT_ACTIVE
	} dbt_state_type;

	// mode register bits that steer training
	typedef struct packed {
		logic       cbt_enable;
		logic       wl_enable;
		logic       fsp_op;
		logic [6:0] vref_prog;
	} dbt_mode_type;

	// status the block shows
	typedef struct packed {
		logic       cbt_active;
		logic       wl_active;
		logic       fsp_in_use;
		logic       decode_enable;
		logic [6:0] vref_in_use;
		logic       vref_settling;
	} dbt_status_type;
endpackage : dbt_pkg

// file: rtl/dbt_core.sv
// dram bus training modes: command bus training and write leveling
`timescale 1ns/1ps
`default_nettype none
module dbt_core #(
	parameter int VREF_LONG  = dbt_pkg::VREF_LONG_CYC,
	parameter int VREF_SHORT = dbt_pkg::VREF_SHORT_CYC,
	parameter int WLO        = dbt_pkg::WLO_CYC
) (
	input  wire logic                    clock_in,
	input  wire logic                    resetn_in,
	input  wire dbt_pkg::dbt_mode_type   mode_in,
	input  wire logic                    cke_in,
	input  wire logic                    ck_in,
	input  wire logic                    cs_in,
	input  wire logic [5:0]              ca_in,
	input  wire logic [1:0]              dqs_in,
	input  wire logic [15:0]             dq_in,
	output logic [15:0]                  dq_out,
	output logic [15:0]                  dq_oe_out,
	output dbt_pkg::dbt_status_type      status_out
);
	if (VREF_LONG < 1 || VREF_SHORT < 1 || VREF_SHORT > VREF_LONG || VREF_LONG > 255 || WLO < 1 || WLO > 255) begin : g_bad_timing
		$error("dbt_core: timing counts out of range");
	end

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	localparam int SW = 1 + 1 + 1 + 6 + 2 + 7;
	logic [SW-1:0] sync1, sync2, next_sync1, next_sync2;
	// cke idles high: no false training entry right after reset
	localparam logic [SW-1:0] SYNC_IDLE = {1'b1, {(SW - 1){1'b0}}};
	logic [1:0]    dqs_prev, next_dqs_prev;
	always_comb begin
		next_sync1    = {cke_in, ck_in, cs_in, ca_in, dqs_in, dq_in[6:0]};
		next_sync2    = sync1;
		next_dqs_prev = sync2[8:7];
	end
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			sync1    <= SYNC_IDLE;
			sync2    <= SYNC_IDLE;
			dqs_prev <= 2'h0;
		end else begin
			sync1    <= next_sync1;
			sync2    <= next_sync2;
			dqs_prev <= next_dqs_prev;
		end
	end
	logic       s_cke, s_ck, s_cs;
	logic [5:0] s_ca;
	logic [1:0] s_dqs, dqs_rise;
	logic [6:0] s_dq;
	assign {s_cke, s_ck, s_cs, s_ca, s_dqs, s_dq} = sync2;
	assign dqs_rise = s_dqs & ~dqs_prev;

	function automatic logic one_step(input logic [6:0] a, input logic [6:0] b);
		return (a[6] == b[6]) && ((a[5:0] == b[5:0] + 6'h01) || (b[5:0] == a[5:0] + 6'h01));
	endfunction : one_step

	// ------------------------------------------------------------
	// command bus training
	// ------------------------------------------------------------
	dbt_pkg::dbt_state_type state, next_state;
	logic       fsp, next_fsp;
	logic [6:0] vref, next_vref, cap, next_cap;
	logic [7:0] settle, next_settle, pulses, next_pulses;
	logic       stat, next_stat;
	logic [5:0] ca_fb, next_ca_fb;
	always_comb begin
		next_state  = state;
		next_fsp    = fsp;
		next_vref   = vref;
		next_cap    = cap;
		next_settle = settle;
		next_pulses = pulses;
		next_stat   = stat;
		next_ca_fb  = ca_fb;
		case (state)
			dbt_pkg::DBT_IDLE: begin
				next_fsp  = mode_in.fsp_op;
				next_vref = mode_in.vref_prog;
				if (mode_in.cbt_enable)
					next_state = dbt_pkg::DBT_CBT_ARMED;
			end
			dbt_pkg::DBT_CBT_ARMED: begin
				next_fsp  = mode_in.fsp_op;
				next_vref = mode_in.vref_prog;
				if (!mode_in.cbt_enable) begin
					next_state = dbt_pkg::DBT_IDLE;
				end else if (!s_cke) begin
					next_state = dbt_pkg::DBT_CBT_ACTIVE;
					next_fsp   = ~mode_in.fsp_op;
				end
			end
			dbt_pkg::DBT_CBT_ACTIVE: begin
				if (s_cs)
					next_ca_fb = s_ca;
				if (dqs_rise[0]) begin
					next_cap    = s_dq;
					next_pulses = (pulses == 8'hff) ? pulses : pulses + dbt_pkg::CNT_ONE;
					next_stat   = (pulses == dbt_pkg::CNT_ZERO) ? 1'b1 : (stat && s_dq == cap);
					next_settle = dbt_pkg::CNT_ZERO;
				end else if (pulses != dbt_pkg::CNT_ZERO) begin
					next_settle = settle + dbt_pkg::CNT_ONE;
					if (settle + dbt_pkg::CNT_ONE >= 8'(VREF_LONG) ||
					    (settle + dbt_pkg::CNT_ONE >= 8'(VREF_SHORT) && one_step(cap, vref) &&
					     (pulses == dbt_pkg::CNT_ONE || stat))) begin
						next_vref   = cap;
						next_pulses = dbt_pkg::CNT_ZERO;
						next_settle = dbt_pkg::CNT_ZERO;
					end
				end
				if (s_cke) begin
					next_state  = dbt_pkg::DBT_CBT_ARMED;
					next_fsp    = mode_in.fsp_op;
					next_vref   = mode_in.vref_prog;
					next_pulses = dbt_pkg::CNT_ZERO;
					next_settle = dbt_pkg::CNT_ZERO;
				end
			end
			default: next_state = dbt_pkg::DBT_IDLE;
		endcase
	end
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			state  <= dbt_pkg::DBT_IDLE;
			fsp    <= 1'b0;
			vref   <= dbt_pkg::VREF_RESET;
			cap    <= 7'h00;
			settle <= 8'h00;
			pulses <= 8'h00;
			stat   <= 1'b0;
			ca_fb  <= 6'h00;
		end else begin
			state  <= next_state;
			fsp    <= next_fsp;
			vref   <= next_vref;
			cap    <= next_cap;
			settle <= next_settle;
			pulses <= next_pulses;
			stat   <= next_stat;
			ca_fb  <= next_ca_fb;
		end
	end

	// ------------------------------------------------------------
	// write leveling, one sampler per strobe lane
	// ------------------------------------------------------------
	logic [1:0] wl_level, next_wl_level, wl_shown, next_wl_shown;
	logic [7:0] wl_cnt [2];
	logic [7:0] next_wl_cnt [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_lane
			always_comb begin
				next_wl_level[g] = wl_level[g];
				next_wl_shown[g] = wl_shown[g];
				next_wl_cnt[g]   = wl_cnt[g];
				if (mode_in.wl_enable && dqs_rise[g]) begin
					next_wl_level[g] = s_ck;
					next_wl_cnt[g]   = 8'(WLO);
				end else if (wl_cnt[g] != dbt_pkg::CNT_ZERO) begin
					next_wl_cnt[g] = wl_cnt[g] - dbt_pkg::CNT_ONE;
					if (wl_cnt[g] == dbt_pkg::CNT_ONE)
						next_wl_shown[g] = wl_level[g];
				end
			end
			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					wl_level[g] <= 1'b0;
					wl_shown[g] <= 1'b0;
					wl_cnt[g]   <= 8'h00;
				end else begin
					wl_level[g] <= next_wl_level[g];
					wl_shown[g] <= next_wl_shown[g];
					wl_cnt[g]   <= next_wl_cnt[g];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic [15:0] next_dq, next_oe;
	always_comb begin
		next_dq = 16'h0000;
		next_oe = 16'h0000;
		if (mode_in.wl_enable) begin
			next_dq = {{8{wl_shown[1]}}, {8{wl_shown[0]}}};
			next_oe = 16'hffff;
		end else if (state == dbt_pkg::DBT_CBT_ACTIVE) begin
			next_dq[13:8] = ca_fb;
			next_oe[13:8] = 6'h3f;
		end
	end
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			dq_out     <= 16'h0000;
			dq_oe_out  <= 16'h0000;
			status_out <= '0;
		end else begin
			dq_out     <= next_dq;
			dq_oe_out  <= next_oe;
			status_out <= '{cbt_active: (next_state == dbt_pkg::DBT_CBT_ACTIVE), wl_active: mode_in.wl_enable,
			                fsp_in_use: next_fsp, decode_enable: (next_state != dbt_pkg::DBT_CBT_ACTIVE),
			                vref_in_use: next_vref, vref_settling: (next_pulses != dbt_pkg::CNT_ZERO)};
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_cbt_enter;
		state == dbt_pkg::DBT_CBT_ARMED && mode_in.cbt_enable && !s_cke;
	endsequence : s_cbt_enter
	sequence s_cbt_leave;
		state == dbt_pkg::DBT_CBT_ACTIVE && s_cke;
	endsequence : s_cbt_leave
	a_fsp_swap: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_cbt_enter |=> (fsp == !$past(mode_in.fsp_op)))
		else $error("set point not swapped");
	a_fsp_revert: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_cbt_leave |=> (fsp == $past(mode_in.fsp_op) && vref == $past(mode_in.vref_prog)))
		else $error("exit did not revert");
	a_decode_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == dbt_pkg::DBT_CBT_ACTIVE && !s_cke) |=> !status_out.decode_enable)
		else $error("decoding not stopped");
	a_vref_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == dbt_pkg::DBT_CBT_ACTIVE && dqs_rise[0] && !s_cke) |=> (cap == $past(s_dq) && vref == $past(vref)))
		else $error("vref capture wrong");
	a_vref_apply: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == dbt_pkg::DBT_CBT_ACTIVE && !s_cke && !dqs_rise[0] && pulses != dbt_pkg::CNT_ZERO &&
		 settle == 8'(VREF_LONG - 1)) |=> (vref == $past(cap)))
		else $error("vref not applied");
	a_settle_max: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(settle <= 8'(VREF_LONG)))
		else $error("settling overran");
	a_wl_feedback: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(mode_in.wl_enable && wl_cnt[0] == dbt_pkg::CNT_ONE) |=> (wl_shown[0] == $past(wl_level[0])))
		else $error("leveling feedback late");
	a_wl_lanes: assert property (@(posedge clock_in) disable iff (!resetn_in)
		$past(mode_in.wl_enable) |-> (dq_out == {{8{$past(wl_shown[1])}}, {8{$past(wl_shown[0])}}} && dq_oe_out == 16'hffff))
		else $error("lane feedback wrong");
	a_cbt_fb: assert property (@(posedge clock_in) disable iff (!resetn_in)
		($past(state) == dbt_pkg::DBT_CBT_ACTIVE && !$past(mode_in.wl_enable)) |-> (dq_out[13:8] == $past(ca_fb)))
		else $error("ca feedback wrong");
	a_cbt_entry: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state == dbt_pkg::DBT_IDLE && mode_in.cbt_enable) |=> (state == dbt_pkg::DBT_CBT_ARMED))
		else $error("training not armed");
endmodule : dbt_core
`default_nettype wire

// file: tb/dbt_ctrl_model.sv
// controller-side model driving the training pins of the block
`timescale 1ns/1ps
`default_nettype none
module dbt_ctrl_model (
	output logic        cke_out,
	output logic        ck_out,
	output logic        cs_out,
	output logic [5:0]  ca_out,
	output logic [1:0]  dqs_out,
	output logic [15:0] dq_out
);
	logic ck_run;
	initial begin
		ck_run = 1'b1;
		cke_out = 1'b1;
		ck_out = 1'b0;
		cs_out = 1'b0;
		ca_out = 6'h00;
		dqs_out = 2'h0;
		dq_out = 16'h5a5a;
	end
	// a stopped clock parks low
	always #100 ck_out = ck_run ? ~ck_out : 1'b0;
	task automatic cbt_enter();
		cke_out = 1'b0;
		#1000;
		ck_run = 1'b0;
	endtask : cbt_enter
	task automatic vref_send(input logic [6:0] v, input int n);
		dq_out = {9'h1ff, v};
		repeat (n) begin
			#50 dqs_out[0] = 1'b1;
			#50 dqs_out[0] = 1'b0;
		end
		// hold time over: data no longer valid
		#50 dq_out = ~dq_out;
	endtask : vref_send
	task automatic cbt_exit();
		ck_run = 1'b1;
		#1000;
		cke_out = 1'b1;
	endtask : cbt_exit
	task automatic ca_send(input logic [5:0] v);
		cs_out = 1'b1;
		ca_out = v;
		#100 cs_out = 1'b0;
		#100 ca_out = 6'h00;
	endtask : ca_send
	task automatic wl_pulse(input int lane, input logic lvl);
		ck_run = 1'b1;
		cs_out = 1'b0;
		if (lvl) @(posedge ck_out);
		else @(negedge ck_out);
		repeat (2) begin
			#5 dqs_out[lane] = 1'b1;
			#30 dqs_out[lane] = 1'b0;
		end
	endtask : wl_pulse
endmodule : dbt_ctrl_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the training block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	typedef struct packed {
		logic       lane;
		logic       lvl;
		logic [7:0] exp;
	} dbt_wl_row_type;
	logic                    clock_in;
	logic                    resetn_in;
	dbt_pkg::dbt_mode_type   mode_in;
	logic                    cke;
	logic                    ck;
	logic                    cs;
	logic [5:0]              ca;
	logic [1:0]              dqs;
	logic [15:0]             dq;
	logic [15:0]             dq_out;
	logic [15:0]             dq_oe_out;
	dbt_pkg::dbt_status_type status_out;
	int                      err_count = 0;
	int                      comparisons = 0;
	dbt_wl_row_type          rows [4] = '{'{1'b0, 1'b1, 8'hff}, '{1'b0, 1'b0, 8'h00},
	                                      '{1'b1, 1'b1, 8'hff}, '{1'b1, 1'b0, 8'h00}};
	dbt_core u_dbt_core (
		.clock_in   (clock_in),
		.resetn_in  (resetn_in),
		.mode_in    (mode_in),
		.cke_in     (cke),
		.ck_in      (ck),
		.cs_in      (cs),
		.ca_in      (ca),
		.dqs_in     (dqs),
		.dq_in      (dq),
		.dq_out     (dq_out),
		.dq_oe_out  (dq_oe_out),
		.status_out (status_out)
	);
	dbt_ctrl_model u_dbt_ctrl_model (
		.cke_out (cke),
		.ck_out  (ck),
		.cs_out  (cs),
		.ca_out  (ca),
		.dqs_out (dqs),
		.dq_out  (dq)
	);
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#2;
	endtask : cyc
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	initial begin
		#200000;
		err_count++;
		final_report();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		mode_in = '0;
		resetn_in = 1'b0;
		cyc(20);
		`CHK(status_out, dbt_pkg::dbt_status_type'(0))
		`CHK(dq_oe_out, 16'h0000)
		resetn_in = 1'b1;
		mode_in.vref_prog = 7'h20;
		cyc(4);
		`CHK(status_out.vref_in_use, 7'h20)
		`CHK(status_out.cbt_active, 1'b0)
		$display("test reset done");
		mode_in.wl_enable = 1'b1;
		cyc(20);
		`CHK(status_out.wl_active, 1'b1)
		foreach (rows[i]) begin
			u_dbt_ctrl_model.wl_pulse(int'(rows[i].lane), rows[i].lvl);
			cyc(8);
			`CHK(dq_out[int'(rows[i].lane) * 8 +: 8], rows[i].exp)
			`CHK(dq_oe_out[int'(rows[i].lane) * 8 +: 8], 8'hff)
		end
		mode_in.wl_enable = 1'b0;
		cyc(4);
		`CHK(status_out.wl_active, 1'b0)
		$display("test write leveling done");
		u_dbt_ctrl_model.cbt_enter();
		cyc(4);
		`CHK(status_out.cbt_active, 1'b0)
		u_dbt_ctrl_model.cbt_exit();
		cyc(4);
		mode_in.cbt_enable = 1'b1;
		cyc(4);
		u_dbt_ctrl_model.cbt_enter();
		cyc(2);
		`CHK(status_out.cbt_active, 1'b1)
		`CHK(status_out.fsp_in_use, 1'b1)
		`CHK(status_out.decode_enable, 1'b0)
		u_dbt_ctrl_model.vref_send(7'h30, 2);
		`CHK(status_out.vref_in_use, 7'h20)
		`CHK(status_out.vref_settling, 1'b1)
		cyc(12);
		`CHK(status_out.vref_in_use, 7'h30)
		`CHK(status_out.vref_settling, 1'b0)
		u_dbt_ctrl_model.vref_send(7'h31, 1);
		cyc(5);
		`CHK(status_out.vref_in_use, 7'h31)
		u_dbt_ctrl_model.ca_send(6'h2b);
		cyc(4);
		`CHK(dq_out[13:8], 6'h2b)
		`CHK(dq_oe_out, 16'h3f00)
		u_dbt_ctrl_model.cbt_exit();
		cyc(4);
		`CHK(status_out.cbt_active, 1'b0)
		`CHK(status_out.fsp_in_use, 1'b0)
		`CHK(status_out.vref_in_use, 7'h20)
		mode_in.cbt_enable = 1'b0;
		cyc(4);
		$display("test command bus training done");
		mode_in.fsp_op = 1'b1;
		mode_in.cbt_enable = 1'b1;
		cyc(4);
		u_dbt_ctrl_model.cbt_enter();
		cyc(2);
		`CHK(status_out.cbt_active, 1'b1)
		`CHK(status_out.fsp_in_use, 1'b0)
		resetn_in = 1'b0;
		mode_in = '{cbt_enable: 1'b0, wl_enable: 1'b0, fsp_op: 1'b0, vref_prog: 7'h20};
		cyc(2);
		`CHK(status_out, dbt_pkg::dbt_status_type'(0))
		`CHK(dq_oe_out, 16'h0000)
		resetn_in = 1'b1;
		cyc(1);
		`CHK(status_out.cbt_active, 1'b0)
		`CHK(status_out.fsp_in_use, 1'b0)
		`CHK(status_out.vref_in_use, 7'h20)
		u_dbt_ctrl_model.cbt_exit();
		cyc(4);
		`CHK(status_out.decode_enable, 1'b1)
		$display("test mid-run reset done");
		final_report();
	end
endmodule : testbench
`default_nettype wire
